// *** dv/cpu_sideband_power_control_tb_top.sv ***
// self-checking bench for the sideband power control block
`timescale 1ns/10ps
`default_nettype none
module cpu_sideband_power_control_tb_top;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic smi_n = 1'h1;
  logic stop_n = 1'h1;
  logic sleep_n = 1'h1;
  logic resume = 1'h0;
  logic tie_hi = 1'h1;
  logic [1:0] tie_lo = 2'h0;
  logic trst_n = 1'h0; // held low through power-on reset
  logic tck = 1'h0;
  logic tms = 1'h1;
  logic tdi = 1'h0;
  logic [3:0] lag = 4'h0;
  logic tdo_out, tdo_oe, save, mode, hstart, creq, cdone, fault;
  logic core, bus, lirq, extb, mult, snoop, irqs, exec;
  logic [1:0] ccode;
  logic [4:0] vid_out, vid_oe, vid_pin;
  logic [7:0] en;
  logic tdo_pin;
  int vid_mv;
  int miscompares = 0;
  int check_count = 0;
  int exp_cyc[$];
  // expected enables: core, bus, irq ctrl, ext bus, mult, snoop, irq, exec
  logic [7:0] en_tab [3] = '{8'hff, 8'h7e, 8'h18};
  assign en = {core, bus, lirq, extb, mult, snoop, irqs, exec};
  // open-drain test output with a board pull-up
  assign tdo_pin = tdo_oe ? tdo_out : 1'h1;

  csbpc_ctrl DUT (.REF_CLK(ref_clk), .RESET(reset), .SYS_MGMT_IRQ_N(smi_n),
    .CLOCK_STOP_REQ_N(stop_n), .SLEEP_REQ_N(sleep_n),
    .RESUME_FROM_MGMT(resume), .SPECIAL_CYCLE_DONE(cdone),
    .FACTORY_TIE_HIGH(tie_hi), .FACTORY_TIE_LOW(tie_lo), .TRST_N(trst_n),
    .TCK(tck), .TMS(tms), .TDI(tdi), .TDO_OUT(tdo_out), .TDO_OE(tdo_oe),
    .VOLTAGE_REQUEST_CODE_OUT(vid_out), .VOLTAGE_REQUEST_CODE_OE(vid_oe),
    .STATE_SAVE(save), .SYS_MGMT_MODE(mode), .HANDLER_START(hstart),
    .SPECIAL_CYCLE_REQ(creq), .SPECIAL_CYCLE_CODE(ccode),
    .CORE_CLK_EN(core), .BUS_UNIT_CLK_EN(bus),
    .LOCAL_IRQ_CONTROLLER_CLK_EN(lirq), .EXT_BUS_CLK_EN(extb),
    .MULTIPLIER_RUN(mult), .SNOOP_EN(snoop), .IRQ_SERVICE_EN(irqs),
    .EXEC_EN(exec), .FACTORY_TIE_FAULT(fault));

  csbpc_chipset_model partner (.clk(ref_clk), .rst(reset), .cyc_req(creq),
    .vid_oe(vid_oe), .lag(lag), .cyc_done(cdone), .vid_pin(vid_pin),
    .vid_mv(vid_mv));

  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_en(input int st);
    int i;
    for (i = 0; i < 20 && en !== en_tab[st]; i++)
      tick(1);
    chk(en, en_tab[st]);
  endtask

  // request may fall at any moment; held two cycles to pass the sync,
  // short enough that the save is still ahead when the task returns
  task automatic smi_pulse;
    smi_n = 1'h0;
    tick(2);
    smi_n = 1'h1;
    tick(1);
  endtask

  task automatic serve_cycle;
    int i;
    int code;
    code = exp_cyc.pop_front();
    lag = 4'($urandom % 6);
    for (i = 0; i < 20 && creq !== 1'h1; i++)
      tick(1);
    chk(ccode, code);
    for (i = 0; i < 30 && cdone !== 1'h1; i++)
      tick(1);
    tick(1);
    chk({creq, hstart}, {1'h0, code == 1});
    tick(1);
    chk(hstart, 1'h0);
  endtask

  task automatic serve_mgmt;
    int i;
    for (i = 0; i < 20 && save !== 1'h1; i++)
      tick(1);
    for (i = 0; i < 20 && save === 1'h1; i++)
      tick(1);
    chk(i, csbpc_pkg::SAVE_CYCLES);
    chk({mode, creq}, 2'h3);
    exp_cyc.push_back(1);
    serve_cycle();
    chk(mode, 1'h1);
    resume = 1'h1;
    tick(1);
    resume = 1'h0;
    tick(2);
    chk(mode, 1'h0);
  endtask

  task automatic stop_run(input bit slp);
    int i;
    stop_n = 1'h0;
    exp_cyc.push_back(2);
    serve_cycle();
    wait_en(1);
    if (slp)
    begin
      sleep_n = 1'h0;
      wait_en(2);
    end
    // in stop grant the interrupt stays pending; in sleep it is dropped
    smi_pulse();
    tick(6);
    chk(en, en_tab[slp ? 2 : 1]);
    sleep_n = 1'h1;
    wait_en(1);
    stop_n = 1'h1;
    wait_en(0);
    if (slp)
    begin
      for (i = 0; i < 20 && save !== 1'h1; i++)
        tick(1);
      chk(i, 20);
    end
    else
      serve_mgmt();
  endtask

  task automatic tck_step(input logic m, input logic d);
    tms = m;
    tdi = d;
    tck = 1'h1;
    tick(4);
    tck = 1'h0;
    tick(4);
  endtask

  initial
  begin
    logic b;
    void'($urandom(32'h6bb7));
    tick(8);
    reset = 1'h0;
    trst_n = 1'h1;
    tick(2);
    chk(en, en_tab[0]);
    chk({save, mode, hstart, creq}, 4'h0);
    chk(vid_mv, 1350);
    chk(vid_out, 5'h0);
    for (int k = 0; k < 8; k++)
    begin
      {tie_hi, tie_lo} = 3'(k);
      tick(1);
      chk(fault, k != 4);
    end
    {tie_hi, tie_lo} = 3'h4;
    $display("test reset and straps done");
    repeat (2)
    begin
      smi_pulse();
      serve_mgmt();
    end
    $display("test management entry done");
    stop_run(1'h0);
    stop_run(1'h1);
    $display("test stop grant and sleep done");
    tck_step(1'h0, 1'h0);
    chk(tdo_pin, 1'h1);
    tck_step(1'h1, 1'h0);
    tck_step(1'h0, 1'h0);
    tck_step(1'h0, 1'h0);
    chk(tdo_pin, 1'h0);
    repeat (6)
    begin
      b = 1'($urandom);
      tck_step(1'h0, b);
      chk(tdo_pin, b);
    end
    tck_step(1'h0, 1'h0);
    chk(tdo_oe, 1'h1);
    // test-port reset acts without any clock edge
    trst_n = 1'h0;
    #5;
    chk(tdo_oe, 1'h0);
    tick(1);
    trst_n = 1'h1;
    $display("test test port done");
    close_out();
  end

  initial
  begin
    repeat (6000) @(posedge ref_clk);
    miscompares++;
    $display("watchdog expired");
    close_out();
  end
endmodule
`default_nettype wire

// *** dv/csbpc_chipset_model.sv ***
// chipset and supply model: special cycle answers and voltage decode
`timescale 1ns/10ps
`default_nettype none
module csbpc_chipset_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_req,
  input wire logic [4:0] vid_oe,
  input wire logic [3:0] lag,
  output logic cyc_done,
  output logic [4:0] vid_pin,
  output int vid_mv
);
  logic [3:0] cnt;
  // board pull-ups: an open ball reads 1, a grounded one reads 0
  assign vid_pin = ~vid_oe;
  // the supply either delivers the decoded level or switches off (0 mV)
  always_comb
  begin
    if (vid_pin[3:0] == 4'hf)
      vid_mv = 0;
    else if (vid_pin[4])
      vid_mv = 1275 - 25 * int'(vid_pin[3:0]);
    else
      vid_mv = 2000 - 50 * int'(vid_pin[3:0]);
  end
  // bus side completes a special cycle lag+1 cycles after the request, one-cycle done
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 4'h0;
      cyc_done <= 1'h0;
    end
    else
    begin
      cyc_done <= cyc_req && !cyc_done && cnt >= lag;
      cnt <= (cyc_req && !cyc_done) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** src/csbpc_ctrl.sv ***
// sideband power control: management entry, stop grant, sleep, voltage code
`timescale 1ns/10ps
`default_nettype none
module csbpc_ctrl #(
  parameter logic [4:0] VID_CODE = csbpc_pkg::VID_BATTERY,
  parameter int unsigned SAVE_CYCLES = csbpc_pkg::SAVE_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic SYS_MGMT_IRQ_N,
  input wire logic CLOCK_STOP_REQ_N,
  input wire logic SLEEP_REQ_N,
  input wire logic RESUME_FROM_MGMT,
  input wire logic SPECIAL_CYCLE_DONE,
  input wire logic FACTORY_TIE_HIGH,
  input wire logic [1:0] FACTORY_TIE_LOW,
  input wire logic TRST_N,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO_OUT,
  output logic TDO_OE,
  output logic [4:0] VOLTAGE_REQUEST_CODE_OUT,
  output logic [4:0] VOLTAGE_REQUEST_CODE_OE,
  output logic STATE_SAVE,
  output logic SYS_MGMT_MODE,
  output logic HANDLER_START,
  output logic SPECIAL_CYCLE_REQ,
  output logic [1:0] SPECIAL_CYCLE_CODE,
  output logic CORE_CLK_EN,
  output logic BUS_UNIT_CLK_EN,
  output logic LOCAL_IRQ_CONTROLLER_CLK_EN,
  output logic EXT_BUS_CLK_EN,
  output logic MULTIPLIER_RUN,
  output logic SNOOP_EN,
  output logic IRQ_SERVICE_EN,
  output logic EXEC_EN,
  output logic FACTORY_TIE_FAULT
);
  csbpc_pkg::csbpc_state_t st;
  csbpc_pkg::csbpc_state_t next_st;
  logic [2:0] sync_q;
  logic smi_s;
  logic smi_q;
  logic stop_req;
  logic sleep_req;
  logic smi_pend;
  logic [7:0] save_cnt;
  logic save_last;
  logic smi_fall;

  // all three requests go through two stages before use [RQ20]
  csbpc_sync #(
    .W(3),
    .INIT(3'h7)
  ) u_sync (
    .clk(REF_CLK),
    .rst(RESET),
    .d({SYS_MGMT_IRQ_N, CLOCK_STOP_REQ_N, SLEEP_REQ_N}),
    .q(sync_q)
  );
  assign smi_s = ~sync_q[2];
  assign stop_req = ~sync_q[1];
  assign sleep_req = ~sync_q[0];

  csbpc_tap u_tap (
    .clk(REF_CLK),
    .trst_n(TRST_N),
    .tck(TCK),
    .tms(TMS),
    .tdi(TDI),
    .tdo_out(TDO_OUT),
    .tdo_oe(TDO_OE)
  );

  // fixed code: a one is left open, a zero is pulled to ground [RQ12] [RQ15]
  assign VOLTAGE_REQUEST_CODE_OUT = '0;
  assign VOLTAGE_REQUEST_CODE_OE = ~VID_CODE;

  // the external party is expected to strap these; we only flag a mismatch
  assign FACTORY_TIE_FAULT = ~FACTORY_TIE_HIGH | (|FACTORY_TIE_LOW);

  // request may arrive at any time; catch its falling edge [RQ1]
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      smi_q <= 1'b0;
    else
      smi_q <= smi_s;
  end
  assign smi_fall = smi_s & ~smi_q;

  // an edge during the cycle the pending flag is taken wins [RQ18]
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      smi_pend <= 1'b0;
    else if (smi_fall && st != csbpc_pkg::CSBPC_SLEEP)
      smi_pend <= 1'b1;
    else if (st == csbpc_pkg::CSBPC_RUN && !stop_req)
      smi_pend <= 1'b0;
  end

  assign save_last = save_cnt == 8'(SAVE_CYCLES - 1);

  always_comb
  begin
    next_st = st;
    unique case (st)
      csbpc_pkg::CSBPC_RUN:
        if (stop_req)
          next_st = csbpc_pkg::CSBPC_STOP_ACK; // [RQ4]
        else if (smi_pend)
          next_st = csbpc_pkg::CSBPC_SAVE; // [RQ2]
      csbpc_pkg::CSBPC_SAVE:
        if (save_last)
          next_st = csbpc_pkg::CSBPC_SMI_ACK; // [RQ3]
      csbpc_pkg::CSBPC_SMI_ACK:
        if (SPECIAL_CYCLE_DONE)
          next_st = csbpc_pkg::CSBPC_RUN;
      csbpc_pkg::CSBPC_STOP_ACK:
        if (SPECIAL_CYCLE_DONE)
          next_st = csbpc_pkg::CSBPC_STOP_GRANT;
      csbpc_pkg::CSBPC_STOP_GRANT:
        if (!stop_req)
          next_st = csbpc_pkg::CSBPC_RUN; // [RQ7]
        else if (sleep_req)
          next_st = csbpc_pkg::CSBPC_SLEEP; // [RQ17]
      csbpc_pkg::CSBPC_SLEEP:
        if (!sleep_req)
          next_st = csbpc_pkg::CSBPC_STOP_GRANT; // [RQ19]
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      st <= csbpc_pkg::CSBPC_RUN;
    else
      st <= next_st;
  end

  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      save_cnt <= '0;
    else if (st == csbpc_pkg::CSBPC_SAVE)
      save_cnt <= save_cnt + 8'h01;
    else
      save_cnt <= '0;
  end

  // mode is entered only once the save has finished [RQ2]
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      SYS_MGMT_MODE <= 1'b0;
    else if (st == csbpc_pkg::CSBPC_SAVE && save_last)
      SYS_MGMT_MODE <= 1'b1;
    else if (RESUME_FROM_MGMT)
      SYS_MGMT_MODE <= 1'b0;
  end

  // handler starts only after the acknowledge cycle completes [RQ3]
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
      HANDLER_START <= 1'b0;
    else
      HANDLER_START <= st == csbpc_pkg::CSBPC_SMI_ACK && SPECIAL_CYCLE_DONE;
  end

  always_comb
  begin
    STATE_SAVE = st == csbpc_pkg::CSBPC_SAVE; // [RQ2]
    SPECIAL_CYCLE_REQ = st == csbpc_pkg::CSBPC_SMI_ACK ||
      st == csbpc_pkg::CSBPC_STOP_ACK;
    SPECIAL_CYCLE_CODE = csbpc_pkg::CSBPC_CYC_NONE;
    if (st == csbpc_pkg::CSBPC_SMI_ACK)
      SPECIAL_CYCLE_CODE = csbpc_pkg::CSBPC_CYC_SMI_ACK; // [RQ3]
    else if (st == csbpc_pkg::CSBPC_STOP_ACK)
      SPECIAL_CYCLE_CODE = csbpc_pkg::CSBPC_CYC_STOP_ACK; // [RQ4]
  end

  // clock gating follows the state; the bus unit keeps its clock until Sleep
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      CORE_CLK_EN <= 1'b1;
      BUS_UNIT_CLK_EN <= 1'b1;
      LOCAL_IRQ_CONTROLLER_CLK_EN <= 1'b1;
      SNOOP_EN <= 1'b1;
      IRQ_SERVICE_EN <= 1'b1;
      EXEC_EN <= 1'b1;
    end
    else
    begin
      CORE_CLK_EN <= next_st != csbpc_pkg::CSBPC_STOP_GRANT &&
        next_st != csbpc_pkg::CSBPC_SLEEP; // [RQ5] [RQ7]
      BUS_UNIT_CLK_EN <= next_st != csbpc_pkg::CSBPC_SLEEP; // [RQ17] [RQ19]
      LOCAL_IRQ_CONTROLLER_CLK_EN <= next_st != csbpc_pkg::CSBPC_SLEEP;
      SNOOP_EN <= next_st != csbpc_pkg::CSBPC_SLEEP; // [RQ6] [RQ18]
      IRQ_SERVICE_EN <= next_st != csbpc_pkg::CSBPC_SLEEP; // [RQ6] [RQ18]
      EXEC_EN <= next_st == csbpc_pkg::CSBPC_RUN; // [RQ7]
    end
  end

  // the bus clock and the multiplier never stop here [RQ8] [RQ17]
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      EXT_BUS_CLK_EN <= 1'b1;
      MULTIPLIER_RUN <= 1'b1;
    end
    else
    begin
      EXT_BUS_CLK_EN <= 1'b1;
      MULTIPLIER_RUN <= 1'b1;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  sync_delay_a: assert property ( // [RQ20]
    $fell(CLOCK_STOP_REQ_N) && st == csbpc_pkg::CSBPC_RUN &&
    !SYS_MGMT_MODE ##1 !CLOCK_STOP_REQ_N [*2] |->
    st == csbpc_pkg::CSBPC_RUN || st == csbpc_pkg::CSBPC_SAVE ||
    st == csbpc_pkg::CSBPC_SMI_ACK)
    else $error("stop request acted on before synchronising");
  save_then_mode_a: assert property ( // [RQ2]
    $rose(SYS_MGMT_MODE) |-> $past(STATE_SAVE))
    else $error("management mode entered without a state save");
  save_length_a: assert property ( // [RQ2]
    $rose(STATE_SAVE) |-> STATE_SAVE [*4] ##1 $rose(SYS_MGMT_MODE))
    else $error("state save has the wrong length");
  smi_ack_a: assert property ( // [RQ3]
    $rose(SYS_MGMT_MODE) |-> SPECIAL_CYCLE_REQ &&
    SPECIAL_CYCLE_CODE == csbpc_pkg::CSBPC_CYC_SMI_ACK)
    else $error("no acknowledge cycle after entering management mode");
  handler_a: assert property ( // [RQ3]
    HANDLER_START |-> $past(SPECIAL_CYCLE_DONE) && SYS_MGMT_MODE)
    else $error("handler started before acknowledge completed");
  stop_ack_a: assert property ( // [RQ4]
    st == csbpc_pkg::CSBPC_STOP_ACK |-> SPECIAL_CYCLE_REQ &&
    SPECIAL_CYCLE_CODE == csbpc_pkg::CSBPC_CYC_STOP_ACK)
    else $error("stop grant acknowledge missing");
  grant_gate_a: assert property ( // [RQ5]
    st == csbpc_pkg::CSBPC_STOP_GRANT |-> !CORE_CLK_EN &&
    BUS_UNIT_CLK_EN && LOCAL_IRQ_CONTROLLER_CLK_EN)
    else $error("wrong clock gating in stop grant");
  grant_snoop_a: assert property ( // [RQ6]
    st == csbpc_pkg::CSBPC_STOP_GRANT |-> SNOOP_EN && IRQ_SERVICE_EN)
    else $error("snoop or interrupts lost in stop grant");
  resume_a: assert property ( // [RQ7]
    st == csbpc_pkg::CSBPC_STOP_GRANT && !stop_req |=>
    CORE_CLK_EN && EXEC_EN)
    else $error("clocks not restarted after stop release");
  bus_clock_a: assert property ( // [RQ8]
    EXT_BUS_CLK_EN && MULTIPLIER_RUN)
    else $error("bus clock or multiplier stopped");
  volt_code_a: assert property ( // [RQ12]
    VOLTAGE_REQUEST_CODE_OE == ~VID_CODE && VOLTAGE_REQUEST_CODE_OUT == '0)
    else $error("voltage code not fixed");
  sleep_gate_a: assert property ( // [RQ17]
    st == csbpc_pkg::CSBPC_SLEEP |-> !BUS_UNIT_CLK_EN && !CORE_CLK_EN &&
    !LOCAL_IRQ_CONTROLLER_CLK_EN)
    else $error("clocks running in sleep");
  sleep_ignore_a: assert property ( // [RQ18]
    st == csbpc_pkg::CSBPC_SLEEP && $past(st == csbpc_pkg::CSBPC_SLEEP) |->
    !SNOOP_EN && !IRQ_SERVICE_EN && $stable(smi_pend))
    else $error("sleep recognised a snoop or interrupt");
  sleep_exit_a: assert property ( // [RQ19]
    st == csbpc_pkg::CSBPC_SLEEP && !sleep_req |=>
    st == csbpc_pkg::CSBPC_STOP_GRANT ##1 BUS_UNIT_CLK_EN)
    else $error("sleep exit did not return to stop grant");

  smi_flow_c: cover property ($rose(HANDLER_START));
  grant_c: cover property (st == csbpc_pkg::CSBPC_STOP_GRANT ##1
    st == csbpc_pkg::CSBPC_RUN);
  sleep_c: cover property (st == csbpc_pkg::CSBPC_SLEEP ##[1:20]
    st == csbpc_pkg::CSBPC_STOP_GRANT);
  smi_in_grant_c: cover property (st == csbpc_pkg::CSBPC_STOP_GRANT &&
    smi_pend ##[1:50] STATE_SAVE);
endmodule
`default_nettype wire

// *** src/csbpc_pkg.sv ***
// constants and types for the sideband power control block
// Notes on behaviour
// RQ1: system logic may pull the management interrupt low at any time, unclocked.
// RQ2: an accepted management interrupt saves state, then enters management mode.
// RQ3: in management mode, issue the acknowledge bus cycle, then start the handler.
// RQ4: a stop-clock request enters Stop Grant and issues its acknowledge cycle.
// RQ5: Stop Grant gates clocks to all units but bus and interrupt controller.
// RQ6: Stop Grant keeps snooping the bus and servicing interrupts.
// RQ7: stop-clock release restarts all unit clocks and resumes execution.
// RQ8: the external bus clock is never gated by a stop-clock request.
// RQ9: the test-port reset input resets the test port asynchronously.
// RQ10: outside party holds test-port reset low during power-on reset.
// RQ11: test data in on TDI, out on open-drain TDO, timed by TCK.
// RQ12: a fixed 5-bit voltage code: open reads 1, grounded reads 0.
// RQ13: supply decodes the code; 01111 and 11111 mean no processor.
// RQ14: the supply delivers the requested voltage or shuts itself off.
// RQ15: dual-frequency parts present the battery-optimized voltage code.
// RQ16: factory test-high is tied high, factory test-lows tied to ground.
// RQ17: sleep request in Stop Grant enters Sleep; only the clock multiplier runs. The code also keeps EXT_BUS_CLK_EN asserted in Sleep.
// RQ18: Sleep ignores snoops and interrupts; only sleep, stop and reset count.
// RQ19: sleep release returns to Stop Grant, restarting bus and irq unit clocks.
// RQ20: asynchronous request inputs pass two flip-flop stages before use.
package csbpc_pkg;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned VID_W = 5;
  // battery-optimized and maximum-performance codes (1.35 V and 1.60 V)
  localparam logic [4:0] VID_BATTERY = 5'h0d;
  localparam logic [4:0] VID_PERFORM = 5'h08;
  localparam logic [4:0] VID_NO_CPU_LO = 5'h0f;
  localparam logic [4:0] VID_NO_CPU_HI = 5'h1f;
  localparam int unsigned SAVE_CYCLES = 4;
  localparam int unsigned TAP_IR_W = 2;
  // special bus cycle codes
  typedef enum logic [1:0] {
    CSBPC_CYC_NONE = 2'h0,
    CSBPC_CYC_SMI_ACK = 2'h1,
    CSBPC_CYC_STOP_ACK = 2'h2
  } csbpc_cyc_t;
  typedef enum {
    CSBPC_RUN,
    CSBPC_SAVE,
    CSBPC_SMI_ACK,
    CSBPC_STOP_ACK,
    CSBPC_STOP_GRANT,
    CSBPC_SLEEP
  } csbpc_state_t;
endpackage

// *** src/csbpc_sync.sv ***
// multi-bit two-stage synchroniser for asynchronous request pins
`timescale 1ns/10ps
`default_nettype none
module csbpc_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  // meta feeds q only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// *** src/csbpc_tap.sv ***
// bypass-only test access port, TCK sampled on the reference clock
`timescale 1ns/10ps
`default_nettype none
module csbpc_tap #(
  parameter int unsigned IR_W = csbpc_pkg::TAP_IR_W
) (
  input wire logic clk,
  input wire logic trst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe
);
  typedef enum {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PAU_DR,
    T_EX2_DR, T_UPD_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PAU_IR,
    T_EX2_IR, T_UPD_IR
  } csbpc_tap_t;
  csbpc_tap_t st;
  csbpc_tap_t next_st;
  logic tck_q;
  logic bypass;
  logic [IR_W-1:0] ir_sh;
  logic out_bit;
  logic shifting;
  wire logic rise = tck & ~tck_q;
  wire logic fall = ~tck & tck_q;
  always_comb
  begin
    next_st = st;
    unique case (st)
      T_RESET: next_st = tms ? T_RESET : T_IDLE;
      T_IDLE: next_st = tms ? T_SEL_DR : T_IDLE;
      T_SEL_DR: next_st = tms ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: next_st = tms ? T_EX1_DR : T_SH_DR;
      T_SH_DR: next_st = tms ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: next_st = tms ? T_UPD_DR : T_PAU_DR;
      T_PAU_DR: next_st = tms ? T_EX2_DR : T_PAU_DR;
      T_EX2_DR: next_st = tms ? T_UPD_DR : T_SH_DR;
      T_UPD_DR: next_st = tms ? T_SEL_DR : T_IDLE;
      T_SEL_IR: next_st = tms ? T_RESET : T_CAP_IR;
      T_CAP_IR: next_st = tms ? T_EX1_IR : T_SH_IR;
      T_SH_IR: next_st = tms ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: next_st = tms ? T_UPD_IR : T_PAU_IR;
      T_PAU_IR: next_st = tms ? T_EX2_IR : T_PAU_IR;
      T_EX2_IR: next_st = tms ? T_UPD_IR : T_SH_IR;
      T_UPD_IR: next_st = tms ? T_SEL_DR : T_IDLE;
    endcase
  end
  // test-port reset is its own asynchronous reset, not the system one [RQ9]
  always_ff @(posedge clk or negedge trst_n)
  begin
    if (!trst_n)
      tck_q <= 1'b0;
    else
      tck_q <= tck;
  end
  always_ff @(posedge clk or negedge trst_n)
  begin
    if (!trst_n)
      st <= T_RESET; // [RQ9]
    else if (rise)
      st <= next_st; // [RQ11]
  end
  // data in on rising TCK [RQ11]
  always_ff @(posedge clk or negedge trst_n)
  begin
    if (!trst_n)
    begin
      bypass <= 1'b0;
      ir_sh <= '0;
    end
    else if (rise)
    begin
      if (st == T_CAP_DR)
        bypass <= 1'b0;
      else if (st == T_SH_DR)
        bypass <= tdi;
      if (st == T_CAP_IR)
        ir_sh <= IR_W'(1);
      else if (st == T_SH_IR)
        ir_sh <= {tdi, ir_sh[IR_W-1:1]};
    end
  end
  // data out changes on falling TCK; open drain pulls only for a zero [RQ11]
  always_ff @(posedge clk or negedge trst_n)
  begin
    if (!trst_n)
    begin
      out_bit <= 1'b1;
      shifting <= 1'b0;
    end
    else if (fall)
    begin
      shifting <= (st == T_SH_DR) || (st == T_SH_IR);
      out_bit <= (st == T_SH_IR) ? ir_sh[0] : bypass;
    end
  end
  assign tdo_out = 1'b0;
  assign tdo_oe = shifting & ~out_bit;
endmodule
`default_nettype wire
